/* core/vfi_top.sv */
// video format indication status block with axi4-lite register access
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
// Operation
// - 720-line codes 07h, 08h, 09h
// - 1080-line 2640 samples give 0Ch-0Fh
// - 1080-line 2750 samples give 10h-13h
// - 525-line 1716 samples give 16h/17h/19h/1Bh
// - hd mode reports luma and chroma formats
// - formats Fh on reset, unlock, pass-through
// - format codes 3h-5h are sdti kinds
// - format codes 0h-8h defined, 9h-Eh reserved, Fh unknown
module vfi_top
  import vfi_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        rate_select_indicator,
  input  wire logic        locked,
  input  wire logic        det_valid,
  input  wire logic [12:0] det_total_samples,
  input  wire logic [10:0] det_active_lines,
  input  wire logic        det_ext_mode,
  input  wire logic        det_seg_frame,
  input  wire logic        det_generic,
  input  wire logic        det_pal_625,
  input  wire logic [3:0]  det_luma_fmt,
  input  wire logic [3:0]  det_chroma_fmt,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [4:0]       video_standard_code,
  output logic [3:0]       luma_format_code,
  output logic [3:0]       chroma_format_code
);
  logic        rate_meta_reg;
  logic        rate_sync_reg;
  logic        lock_meta_reg;
  logic        lock_sync_reg;
  logic        pass_reg;
  logic [4:0]  std_reg;
  logic [4:0]  std_next;
  logic [3:0]  luma_reg;
  logic [3:0]  luma_next;
  logic [3:0]  chroma_reg;
  logic [3:0]  chroma_next;
  logic [4:0]  std_raw;
  logic        aw_held_reg;
  logic [3:0]  aw_addr_reg;
  logic        w_held_reg;
  logic [31:0] w_data_reg;
  logic        w_strb0_reg;
  wire         wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire         wr_ctrl = wr_fire && aw_addr_reg == VFI_OFF_CONTROL;
  wire         rd_fire = s_axi_arvalid && s_axi_arready;

  // format codes only take defined values; reserved ones fall to unknown
  function automatic logic [3:0] vfi_fmt_clean(input logic [3:0] code);
    vfi_fmt_clean = (code > VFI_FMT_TDM) ? VFI_FMT_UNKNOWN : code;
  endfunction

  // pin inputs pass two flops before use
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rate_meta_reg <= 1'b0;
      rate_sync_reg <= 1'b0;
      lock_meta_reg <= 1'b0;
      lock_sync_reg <= 1'b0;
    end else begin
      rate_meta_reg <= rate_select_indicator;
      rate_sync_reg <= rate_meta_reg;
      lock_meta_reg <= locked;
      lock_sync_reg <= lock_meta_reg;
    end
  end

  vfi_std_decode u_decode (
    .sd_mode       (rate_sync_reg),
    .total_samples (det_total_samples),
    .active_lines  (det_active_lines),
    .ext_mode      (det_ext_mode),
    .seg_frame     (det_seg_frame),
    .generic       (det_generic),
    .pal_625       (det_pal_625),
    .std_code      (std_raw)
  );

  // next status values
  wire fmt_clear = !lock_sync_reg || pass_reg;
  always_comb begin
    std_next    = std_reg;
    luma_next   = luma_reg;
    chroma_next = chroma_reg;
    if (det_valid) begin
      std_next = std_raw;
    end
    if (fmt_clear) begin
      luma_next   = VFI_FMT_UNKNOWN;
      chroma_next = VFI_FMT_UNKNOWN;
    end else if (det_valid) begin
      luma_next   = vfi_fmt_clean(det_luma_fmt);
      chroma_next = rate_sync_reg ? VFI_FMT_UNKNOWN
                                  : vfi_fmt_clean(det_chroma_fmt);
    end else if (rate_sync_reg) begin
      chroma_next = VFI_FMT_UNKNOWN;
    end
  end

  // status registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      std_reg    <= VFI_STD_RST;
      luma_reg   <= VFI_FMT_UNKNOWN;
      chroma_reg <= VFI_FMT_UNKNOWN;
    end else begin
      std_reg    <= std_next;
      luma_reg   <= luma_next;
      chroma_reg <= chroma_next;
    end
  end

  assign video_standard_code = std_reg;
  assign luma_format_code    = luma_reg;
  assign chroma_format_code  = chroma_reg;

  // write channel capture, either order
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_reg  <= 1'b0;
      aw_addr_reg  <= 4'h0;
      w_held_reg   <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_strb0_reg  <= 1'b0;
      s_axi_bvalid <= 1'b0;
      pass_reg     <= VFI_PASS_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg  <= 1'b1;
        w_data_reg  <= s_axi_wdata;
        w_strb0_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wr_ctrl && w_strb0_reg) begin
          pass_reg <= w_data_reg[VFI_POS_PASS];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // write answer codes
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bresp <= VFI_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bresp <= wr_ctrl ? VFI_RESP_OKAY : VFI_RESP_SLVERR;
    end
  end

  // ready flags registered so outputs come from flops
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      s_axi_arready <= !s_axi_rvalid && !rd_fire;
    end
  end

  // read data selection
  wire [31:0] status_word = {14'h0000, lock_sync_reg, rate_sync_reg,
                             chroma_reg, luma_reg, 3'h0, std_reg};
  wire        rd_ok  = s_axi_araddr == VFI_OFF_STATUS || s_axi_araddr == VFI_OFF_CONTROL;
  wire [31:0] rd_sel = (s_axi_araddr == VFI_OFF_STATUS) ? status_word :
                       (s_axi_araddr == VFI_OFF_CONTROL) ? {31'h0000_0000, pass_reg} :
                       32'h0000_0000;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= VFI_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_sel;
      s_axi_rresp  <= rd_ok ? VFI_RESP_OKAY : VFI_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  a_fmt_unlock_clear: assert property (@(posedge clock) disable iff (!reset_n)
    !lock_sync_reg |=> luma_reg == VFI_FMT_UNKNOWN && chroma_reg == VFI_FMT_UNKNOWN)
    else $error("format not unknown after unlock");
  a_fmt_pass_clear: assert property (@(posedge clock) disable iff (!reset_n)
    pass_reg |=> luma_reg == VFI_FMT_UNKNOWN && chroma_reg == VFI_FMT_UNKNOWN)
    else $error("format not unknown in pass-through");
  a_chroma_sd_ones: assert property (@(posedge clock) disable iff (!reset_n)
    rate_sync_reg |=> chroma_reg == VFI_FMT_UNKNOWN)
    else $error("chroma not unknown in sd");
  a_fmt_hd_load: assert property (@(posedge clock) disable iff (!reset_n)
    det_valid && !fmt_clear && !rate_sync_reg && det_chroma_fmt <= VFI_FMT_TDM
    |=> chroma_reg == $past(det_chroma_fmt) && luma_reg == vfi_fmt_clean($past(det_luma_fmt)))
    else $error("hd formats not loaded");
  a_fmt_no_rsv: assert property (@(posedge clock) disable iff (!reset_n)
    luma_reg <= VFI_FMT_TDM || luma_reg == VFI_FMT_UNKNOWN)
    else $error("reserved luma format");
  a_std_no_rsv: assert property (@(posedge clock) disable iff (!reset_n)
    std_reg != VFI_STD_RSV_A && std_reg != VFI_STD_RSV_B)
    else $error("reserved standard code");
  a_std_720_24: assert property (@(posedge clock) disable iff (!reset_n)
    det_valid && !rate_sync_reg && det_total_samples == VFI_TS_4125
    |=> std_reg == ($past(det_ext_mode) ? VFI_STD_720_24_EM : VFI_STD_720_24))
    else $error("720 24 code wrong");
  a_std_1080_25: assert property (@(posedge clock) disable iff (!reset_n)
    det_valid && !rate_sync_reg && det_total_samples == VFI_TS_2640
    |=> std_reg >= VFI_STD_1080_25I && std_reg <= VFI_STD_1080_25S_EM)
    else $error("1080 2640 code out of range");
  a_std_1080_24: assert property (@(posedge clock) disable iff (!reset_n)
    det_valid && !rate_sync_reg && det_total_samples == VFI_TS_2750
    |=> std_reg >= VFI_STD_1080_24P && std_reg <= VFI_STD_1080_24S_EM)
    else $error("1080 2750 code out of range");
  a_std_525: assert property (@(posedge clock) disable iff (!reset_n)
    det_valid && rate_sync_reg && !det_pal_625 && det_total_samples == VFI_TS_1716
    && det_active_lines == VFI_AL_487 && !det_generic |=> std_reg == VFI_STD_525_487)
    else $error("525 487 code wrong");
endmodule

/* core/vfi_pkg.sv */
// package of codes, offsets and reset values for the video format indication block
package vfi_pkg;
  // standard codes
  localparam logic [4:0] VFI_STD_720_25_EM  = 5'h07;
  localparam logic [4:0] VFI_STD_720_24     = 5'h08;
  localparam logic [4:0] VFI_STD_720_24_EM  = 5'h09;
  localparam logic [4:0] VFI_STD_1080_2200I = 5'h0A;
  localparam logic [4:0] VFI_STD_1080_2200P = 5'h0B;
  localparam logic [4:0] VFI_STD_1080_25I   = 5'h0C;
  localparam logic [4:0] VFI_STD_1080_25P   = 5'h0D;
  localparam logic [4:0] VFI_STD_1080_25P_EM = 5'h0E;
  localparam logic [4:0] VFI_STD_1080_25S_EM = 5'h0F;
  localparam logic [4:0] VFI_STD_1080_24P   = 5'h10;
  localparam logic [4:0] VFI_STD_1080_24S   = 5'h11;
  localparam logic [4:0] VFI_STD_1080_24P_EM = 5'h12;
  localparam logic [4:0] VFI_STD_1080_24S_EM = 5'h13;
  localparam logic [4:0] VFI_STD_525_487    = 5'h16;
  localparam logic [4:0] VFI_STD_525_507    = 5'h17;
  localparam logic [4:0] VFI_STD_625        = 5'h18;
  localparam logic [4:0] VFI_STD_525_487_G  = 5'h19;
  localparam logic [4:0] VFI_STD_625_G      = 5'h1A;
  localparam logic [4:0] VFI_STD_525_507_G  = 5'h1B;
  localparam logic [4:0] VFI_STD_RSV_A      = 5'h1C;
  localparam logic [4:0] VFI_STD_UNK_HD     = 5'h1D;
  localparam logic [4:0] VFI_STD_UNK_SD     = 5'h1E;
  localparam logic [4:0] VFI_STD_RSV_B      = 5'h1F;
  localparam logic [4:0] VFI_STD_RST        = 5'h1E;
  // total samples per line
  localparam logic [12:0] VFI_TS_3960 = 13'h0F78;
  localparam logic [12:0] VFI_TS_4125 = 13'h101D;
  localparam logic [12:0] VFI_TS_2200 = 13'h0898;
  localparam logic [12:0] VFI_TS_2640 = 13'h0A50;
  localparam logic [12:0] VFI_TS_2750 = 13'h0ABE;
  localparam logic [12:0] VFI_TS_1716 = 13'h06B4;
  localparam logic [12:0] VFI_TS_1728 = 13'h06C0;
  // active line counts for 525-line signals
  localparam logic [10:0] VFI_AL_487 = 11'h1E7;
  localparam logic [10:0] VFI_AL_507 = 11'h1FB;
  // data format codes
  localparam logic [3:0] VFI_FMT_DVCPRO    = 4'h0;
  localparam logic [3:0] VFI_FMT_DVCPRO_EC = 4'h1;
  localparam logic [3:0] VFI_FMT_DVCAM     = 4'h2;
  localparam logic [3:0] VFI_FMT_SDTI_CP   = 4'h3;
  localparam logic [3:0] VFI_FMT_SDTI_FIX  = 4'h4;
  localparam logic [3:0] VFI_FMT_SDTI_VAR  = 4'h5;
  localparam logic [3:0] VFI_FMT_SDI       = 4'h6;
  localparam logic [3:0] VFI_FMT_ASI       = 4'h7;
  localparam logic [3:0] VFI_FMT_TDM       = 4'h8;
  localparam logic [3:0] VFI_FMT_UNKNOWN   = 4'hF;
  // register byte offsets
  localparam logic [3:0] VFI_OFF_STATUS  = 4'h0;
  localparam logic [3:0] VFI_OFF_CONTROL = 4'h4;
  // field positions in the status word and the control word
  localparam int VFI_POS_STD  = 0;
  localparam int VFI_POS_LUMA = 8;
  localparam int VFI_POS_CHR  = 12;
  localparam int VFI_POS_RATE = 16;
  localparam int VFI_POS_LOCK = 17;
  localparam int VFI_POS_PASS = 0;
  localparam logic [1:0] VFI_RESP_OKAY   = 2'h0;
  localparam logic [1:0] VFI_RESP_SLVERR = 2'h2;
  localparam logic       VFI_PASS_RST    = 1'b0;
endpackage

/* core/vfi_std_decode.sv */
// combinational classifier from measured line timing to standard code
`timescale 1ns/1ps
module vfi_std_decode
  import vfi_pkg::*;
(
  input  wire logic        sd_mode,
  input  wire logic [12:0] total_samples,
  input  wire logic [10:0] active_lines,
  input  wire logic        ext_mode,
  input  wire logic        seg_frame,
  input  wire logic        generic,
  input  wire logic        pal_625,
  output logic [4:0]       std_code
);
  // classify; fallbacks give unknown codes so reserved codes never appear
  always_comb begin
    std_code = sd_mode ? VFI_STD_UNK_SD : VFI_STD_UNK_HD;
    if (!sd_mode) begin
      if (total_samples == VFI_TS_3960 && ext_mode) begin
        std_code = VFI_STD_720_25_EM;
      end else if (total_samples == VFI_TS_4125) begin
        std_code = ext_mode ? VFI_STD_720_24_EM : VFI_STD_720_24;
      end else if (total_samples == VFI_TS_2200 && !ext_mode) begin
        std_code = seg_frame ? VFI_STD_1080_2200I : VFI_STD_1080_2200P;
      end else if (total_samples == VFI_TS_2640) begin
        case ({ext_mode, seg_frame})
          2'b00:   std_code = VFI_STD_1080_25P;
          2'b01:   std_code = VFI_STD_1080_25I;
          2'b10:   std_code = VFI_STD_1080_25P_EM;
          default: std_code = VFI_STD_1080_25S_EM;
        endcase
      end else if (total_samples == VFI_TS_2750) begin
        case ({ext_mode, seg_frame})
          2'b00:   std_code = VFI_STD_1080_24P;
          2'b01:   std_code = VFI_STD_1080_24S;
          2'b10:   std_code = VFI_STD_1080_24P_EM;
          default: std_code = VFI_STD_1080_24S_EM;
        endcase
      end
    end else if (pal_625 && total_samples == VFI_TS_1728) begin
      std_code = generic ? VFI_STD_625_G : VFI_STD_625;
    end else if (!pal_625 && total_samples == VFI_TS_1716) begin
      if (active_lines == VFI_AL_487) begin
        std_code = generic ? VFI_STD_525_487_G : VFI_STD_525_487;
      end else if (active_lines == VFI_AL_507) begin
        std_code = generic ? VFI_STD_525_507_G : VFI_STD_525_507;
      end
    end
  end
endmodule

/* verification/vfi_top_test.sv */
// self-checking bench for the video format indication block
`timescale 1ns/1ps
module vfi_top_test
  import vfi_pkg::*;
;
  logic        clock, reset_n, rate_select_indicator, locked, det_valid;
  logic        det_ext_mode, det_seg_frame, det_generic, det_pal_625;
  logic [12:0] det_total_samples;
  logic [10:0] det_active_lines;
  logic [3:0]  det_luma_fmt, det_chroma_fmt, s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [3:0]  luma_format_code, chroma_format_code;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [4:0]  video_standard_code;
  int          n_errors, tests_run;

  // device under test, every port by name
  vfi_top i_dut (
    .clock, .reset_n, .rate_select_indicator, .locked, .det_valid, .det_total_samples,
    .det_active_lines, .det_ext_mode, .det_seg_frame, .det_generic, .det_pal_625,
    .det_luma_fmt, .det_chroma_fmt, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .video_standard_code, .luma_format_code,
    .chroma_format_code
  );

  // 20 MHz clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic report_and_stop();
    $display("counts: %0d compares, %0d mismatches", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // reserved format inputs read back as unknown
  function automatic logic [3:0] fx(input logic [3:0] x);
    return (x > 4'h8) ? 4'hF : x;
  endfunction

  // one axi4-lite write, address and data offered together
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 100);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    check(32'(n < 100), 32'h1, "write answer");
  endtask

  // one axi4-lite read
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 100);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    check(32'(n < 100), 32'h1, "read answer");
  endtask

  // present one detector result for a single cycle
  task automatic det(input logic [12:0] ts, input logic [10:0] al, input logic e, s, g,
                     input logic [3:0] lf, cf);
    @(posedge clock);
    det_total_samples <= ts;
    det_active_lines  <= al;
    det_ext_mode      <= e;
    det_seg_frame     <= s;
    det_generic       <= g;
    det_luma_fmt      <= lf;
    det_chroma_fmt    <= cf;
    det_valid         <= 1'b1;
    @(posedge clock);
    det_valid <= 1'b0;
    @(negedge clock);
  endtask

  // standard code case
  task automatic sc(input logic [12:0] ts, input logic [10:0] al, input logic e, s, g,
                    input logic [4:0] exp);
    det(ts, al, e, s, g, 4'h3, 4'h5);
    check(32'(video_standard_code), 32'(exp), "standard code");
  endtask

  // change the synchronised pins and let them settle
  task automatic pins(input logic r, l);
    @(posedge clock);
    rate_select_indicator <= r;
    locked                <= l;
    repeat (4) @(posedge clock);
    @(negedge clock);
  endtask

  // format pair check
  task automatic fc(input logic [3:0] lf, cf);
    check(32'(luma_format_code), 32'(lf), "luma format");
    check(32'(chroma_format_code), 32'(cf), "chroma format");
  endtask

  // watchdog
  initial begin
    #(20000 * 50);
    n_errors++;
    $display("FAIL t=%0t watchdog expired", $time);
    report_and_stop();
  end

  // test sequence
  initial begin
    {reset_n, rate_select_indicator, det_valid, det_ext_mode, det_seg_frame} = '0;
    {det_generic, det_pal_625, det_total_samples, det_active_lines} = '0;
    {det_luma_fmt, det_chroma_fmt, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {n_errors, tests_run} = '0;
    locked = 1'b1;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge clock);
    @(negedge clock);
    check(32'(video_standard_code), 32'(VFI_STD_RST), "reset standard");
    fc(4'hF, 4'hF);
    @(posedge clock);
    reset_n <= 1'b1;
    pins(1'b0, 1'b1);
    axi_read(VFI_OFF_CONTROL, rd, rsp);
    check(rd, 32'h0, "control reset");
    axi_read(VFI_OFF_STATUS, rd, rsp);
    check(rd, 32'h0002_FF1E, "status reset");
    check(32'(rsp), 32'(VFI_RESP_OKAY), "status read answer");
    $display("test reset done");
    sc(VFI_TS_3960, 11'h0, 1'b1, 1'b0, 1'b0, 5'h07);
    sc(VFI_TS_4125, 11'h0, 1'b0, 1'b0, 1'b0, 5'h08);
    sc(VFI_TS_4125, 11'h0, 1'b1, 1'b0, 1'b0, 5'h09);
    sc(VFI_TS_2640, 11'h0, 1'b0, 1'b1, 1'b0, 5'h0C);
    sc(VFI_TS_2640, 11'h0, 1'b0, 1'b0, 1'b0, 5'h0D);
    sc(VFI_TS_2640, 11'h0, 1'b1, 1'b0, 1'b0, 5'h0E);
    sc(VFI_TS_2640, 11'h0, 1'b1, 1'b1, 1'b0, 5'h0F);
    sc(13'h04D2, 11'h0, 1'b0, 1'b0, 1'b0, 5'h1D);
    sc(VFI_TS_2200, 11'h0, 1'b0, 1'b1, 1'b0, 5'h0A);
    sc(VFI_TS_2200, 11'h0, 1'b0, 1'b0, 1'b0, 5'h0B);
    sc(VFI_TS_2750, 11'h0, 1'b0, 1'b0, 1'b0, 5'h10);
    sc(VFI_TS_2750, 11'h0, 1'b0, 1'b1, 1'b0, 5'h11);
    sc(VFI_TS_2750, 11'h0, 1'b1, 1'b0, 1'b0, 5'h12);
    sc(VFI_TS_2750, 11'h0, 1'b1, 1'b1, 1'b0, 5'h13);
    axi_read(VFI_OFF_STATUS, rd, rsp);
    check(rd, 32'h0002_5313, "status hd");
    for (int i = 0; i < 16; i++) begin
      det(VFI_TS_2750, 11'h0, 1'b0, 1'b0, 1'b0, 4'(i), 4'(15 - i));
      fc(fx(4'(i)), fx(4'(15 - i)));
    end
    $display("test hd done");
    pins(1'b1, 1'b1);
    sc(VFI_TS_1716, VFI_AL_487, 1'b0, 1'b0, 1'b0, 5'h16);
    sc(VFI_TS_1716, VFI_AL_507, 1'b0, 1'b0, 1'b0, 5'h17);
    sc(VFI_TS_1716, VFI_AL_487, 1'b0, 1'b0, 1'b1, 5'h19);
    sc(VFI_TS_1716, VFI_AL_507, 1'b0, 1'b0, 1'b1, 5'h1B);
    sc(13'h04D2, VFI_AL_487, 1'b0, 1'b0, 1'b0, 5'h1E);
    sc(VFI_TS_1716, 11'h100, 1'b0, 1'b0, 1'b0, 5'h1E);
    @(posedge clock);
    det_pal_625 <= 1'b1;
    sc(VFI_TS_1728, 11'h0, 1'b0, 1'b0, 1'b0, 5'h18);
    sc(VFI_TS_1728, 11'h0, 1'b0, 1'b0, 1'b1, 5'h1A);
    sc(VFI_TS_1716, VFI_AL_487, 1'b0, 1'b0, 1'b0, 5'h1E);
    @(posedge clock);
    det_pal_625 <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      det(VFI_TS_1716, VFI_AL_487, 1'b0, 1'b0, 1'b0, 4'(i), 4'(i));
      fc(fx(4'(i)), 4'hF);
    end
    axi_read(VFI_OFF_STATUS, rd, rsp);
    check(rd, 32'h0003_FF16, "status sd");
    $display("test sd done");
    pins(1'b0, 1'b1);
    det(VFI_TS_2640, 11'h0, 1'b0, 1'b1, 1'b0, 4'h6, 4'h2);
    fc(4'h6, 4'h2);
    pins(1'b0, 1'b0);
    fc(4'hF, 4'hF);
    check(32'(video_standard_code), 32'h0C, "standard kept");
    pins(1'b0, 1'b1);
    det(VFI_TS_2640, 11'h0, 1'b0, 1'b1, 1'b0, 4'h6, 4'h2);
    fc(4'h6, 4'h2);
    $display("test unlock done");
    axi_write(VFI_OFF_CONTROL, 32'h1, rsp);
    check(32'(rsp), 32'(VFI_RESP_OKAY), "control write");
    repeat (2) @(posedge clock);
    @(negedge clock);
    fc(4'hF, 4'hF);
    axi_read(VFI_OFF_CONTROL, rd, rsp);
    check(rd, 32'h1, "control readback");
    axi_write(VFI_OFF_CONTROL, 32'h0, rsp);
    det(VFI_TS_2640, 11'h0, 1'b0, 1'b1, 1'b0, 4'h7, 4'h8);
    fc(4'h7, 4'h8);
    $display("test pass-through done");
    // second reset in mid-run clears formats and standard again
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    fc(4'hF, 4'hF);
    check(32'(video_standard_code), 32'(VFI_STD_RST), "standard after reset");
    @(posedge clock);
    reset_n <= 1'b1;
    pins(1'b0, 1'b1);
    $display("test mid-run reset done");
    axi_write(4'h8, 32'h1, rsp);
    check(32'(rsp), 32'(VFI_RESP_SLVERR), "unmapped write");
    axi_read(4'hC, rd, rsp);
    check(rd, 32'h0, "unmapped data");
    check(32'(rsp), 32'(VFI_RESP_SLVERR), "unmapped read");
    axi_read(VFI_OFF_CONTROL, rd, rsp);
    check(rd, 32'h0, "control untouched");
    $display("test unmapped done");
    // control bit only written when byte lane 0 is enabled
    @(posedge clock);
    s_axi_wstrb <= 4'hE;
    axi_write(VFI_OFF_CONTROL, 32'h1, rsp);
    axi_read(VFI_OFF_CONTROL, rd, rsp);
    check(rd, 32'h0, "strobe gates control");
    @(posedge clock);
    s_axi_wstrb <= 4'hF;
    $display("test strobe done");
    report_and_stop();
  end
endmodule
